// ==== hw/ubd_pkg.sv ====
// constants, states and state records for the mode 1 serial port
// assumes one core clock and a synchronous active-low reset everywhere
package ubd_pkg;

  // ---------------------------------------------------------------
  // frame and sampling figures
  // ---------------------------------------------------------------
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = 10;
  localparam logic [3:0] TICK_LAST = 4'hf;   // sixteen ticks per bit
  localparam logic [3:0] TICK_MID = 4'h7;    // centre of the start bit
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic LINE_IDLE = 1'b1;

  // ---------------------------------------------------------------
  // timer figures
  // ---------------------------------------------------------------
  localparam logic [7:0] T1_TOP = 8'hff;
  localparam logic [15:0] T2_TOP = 16'hffff;
  localparam logic [3:0] PRESCALE_LAST = 4'hb;  // divide by 12
  localparam logic [1:0] T1_CLK_CORE = 2'h0;
  localparam logic [1:0] T1_CLK_DIV12 = 2'h1;
  localparam logic [1:0] T1_CLK_EXT = 2'h2;

  // ---------------------------------------------------------------
  // states and state records
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {UBD_IDLE, UBD_START, UBD_DATA, UBD_STOP} ubd_phase_t;

  typedef struct packed {
    logic [7:0] t1;
    logic [15:0] t2;
    logic [3:0] pre;
    logic ext_meta;
    logic ext_s;
    logic ext_prev;
    logic half;
    logic tx_tick16;
    logic rx_tick16;
  } ubd_baud_state_t;

  typedef struct packed {
    ubd_phase_t tx_st;
    logic [3:0] tx_tick;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_pin;
    logic rx_meta;
    logic rx_s;
    logic rx_prev;
    ubd_phase_t rx_st;
    logic [3:0] rx_tick;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic [7:0] serial_buffer;
    logic ninth_bit;
    logic tx_done;
    logic rx_done;
    logic irq;
    logic busy;
  } ubd_top_state_t;

endpackage

// ==== hw/ubd_baud_gen.sv ====
// timer 1 auto-reload and timer 2 baud generator, giving 16x ticks
// assumes the external count pin is asynchronous to the core clock
`timescale 1ns/1ps
module ubd_baud_gen (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic t1_ext_pin,
  input wire logic [1:0] t1_clk_sel,
  input wire logic [7:0] timer1_reload_byte,
  input wire logic [15:0] t2_reload,
  input wire logic baud_doubler_bit,
  input wire logic tx_src_t2,
  input wire logic rx_src_t2,
  output logic tx_tick16,
  output logic rx_tick16
);

  ubd_pkg::ubd_baud_state_t s, next_s;
  logic t1_en;
  logic t1_ovf;
  logic t2_ovf;
  logic t1_tick16;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.ext_meta = t1_ext_pin;
    next_s.ext_s = s.ext_meta;
    next_s.ext_prev = s.ext_s;
    // prescaler runs free so the /12 rate does not depend on the select
    next_s.pre = (s.pre == ubd_pkg::PRESCALE_LAST) ? 4'h0 : s.pre + 4'h1;
    if (t1_clk_sel == ubd_pkg::T1_CLK_CORE) begin
      t1_en = 1'b1;
    end else if (t1_clk_sel == ubd_pkg::T1_CLK_DIV12) begin
      t1_en = (s.pre == ubd_pkg::PRESCALE_LAST);
    end else if (t1_clk_sel == ubd_pkg::T1_CLK_EXT) begin
      t1_en = s.ext_s & ~s.ext_prev;   // rising edge of the pin
    end else begin
      t1_en = 1'b0;
    end
    // rollover from top reloads, so the period is 256 minus reload
    t1_ovf = t1_en && (s.t1 == ubd_pkg::T1_TOP);
    if (t1_ovf) begin
      next_s.t1 = timer1_reload_byte;
    end else if (t1_en) begin
      next_s.t1 = s.t1 + 8'h01;
    end
    t2_ovf = (s.t2 == ubd_pkg::T2_TOP);
    next_s.t2 = t2_ovf ? t2_reload : s.t2 + 16'h0001;
    // halving stage: 16x clock is t1 overflow/2, or every overflow doubled
    if (t1_ovf) begin
      next_s.half = ~s.half;
    end
    t1_tick16 = t1_ovf && (baud_doubler_bit || s.half);
    next_s.tx_tick16 = tx_src_t2 ? t2_ovf : t1_tick16;
    next_s.rx_tick16 = rx_src_t2 ? t2_ovf : t1_tick16;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tx_tick16 = s.tx_tick16;
  assign rx_tick16 = s.rx_tick16;

  a_t1_reload: assert property (@(posedge clock) disable iff (!rst_n)
    t1_ovf |=> s.t1 == $past(timer1_reload_byte)) else $error("timer 1 did not reload");
  a_t2_tick: assert property (@(posedge clock) disable iff (!rst_n)
    (t2_ovf && rx_src_t2) |=> rx_tick16) else $error("timer 2 overflow lost");

endmodule

// ==== hw/ubd_uart_mode1.sv ====
// mode 1 serial port: ten-bit asynchronous transmitter and receiver
// assumes control bits come from core logic on the same clock; rx pin is async
`timescale 1ns/1ps
module ubd_uart_mode1 (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rx_pin,
  input wire logic t1_ext_pin,
  input wire logic [1:0] t1_clk_sel,
  input wire logic [7:0] timer1_reload_byte,
  input wire logic [15:0] t2_reload,
  input wire logic baud_doubler_bit,
  input wire logic tx_src_t2,
  input wire logic rx_src_t2,
  input wire logic receive_enable,
  input wire logic multiprocessor_check_bit,
  input wire logic interrupt_enable,
  input wire logic wr_serial_buffer,
  input wire logic [7:0] wr_data,
  input wire logic clr_transmit_done,
  input wire logic clr_receive_done,
  output logic tx_pin,
  output logic [7:0] serial_buffer,
  output logic received_ninth_bit_flag,
  output logic transmit_done_flag,
  output logic receive_done_flag,
  output logic serial_irq,
  output logic tx_busy
);

  ubd_pkg::ubd_top_state_t s, next_s;
  logic tx_tick16;
  logic rx_tick16;
  logic rx_load;
  logic rx_stop_done;
  logic tx_done_set;

  // end of a bit window, shared by both directions
  function automatic logic bit_end(input logic [3:0] tick);
    bit_end = (tick == ubd_pkg::TICK_LAST);
  endfunction

  // ---------------------------------------------------------------
  // baud ticks
  // ---------------------------------------------------------------
  ubd_baud_gen u_baud (
    .clock(clock),
    .rst_n(rst_n),
    .t1_ext_pin(t1_ext_pin),
    .t1_clk_sel(t1_clk_sel),
    .timer1_reload_byte(timer1_reload_byte),
    .t2_reload(t2_reload),
    .baud_doubler_bit(baud_doubler_bit),
    .tx_src_t2(tx_src_t2),
    .rx_src_t2(rx_src_t2),
    .tx_tick16(tx_tick16),
    .rx_tick16(rx_tick16)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    tx_done_set = 1'b0;
    rx_load = 1'b0;
    rx_stop_done = 1'b0;

    // transmitter; writes while busy are dropped, also in the stop bit after done rises; software waits for busy low
    case (s.tx_st)
      ubd_pkg::UBD_IDLE: begin
        next_s.tx_pin = ubd_pkg::LINE_IDLE;
        if (wr_serial_buffer) begin
          next_s.tx_shift = wr_data;
          next_s.tx_st = ubd_pkg::UBD_START;
          next_s.tx_tick = 4'h0;
          next_s.tx_pin = 1'b0;
        end
      end
      ubd_pkg::UBD_START: begin
        if (tx_tick16) begin
          next_s.tx_tick = s.tx_tick + 4'h1;
          if (bit_end(s.tx_tick)) begin
            next_s.tx_st = ubd_pkg::UBD_DATA;
            next_s.tx_bit = 3'h0;
            next_s.tx_pin = s.tx_shift[0];
          end
        end
      end
      ubd_pkg::UBD_DATA: begin
        if (tx_tick16) begin
          next_s.tx_tick = s.tx_tick + 4'h1;
          if (bit_end(s.tx_tick)) begin
            if (s.tx_bit == ubd_pkg::BIT_LAST) begin
              next_s.tx_st = ubd_pkg::UBD_STOP;
              next_s.tx_pin = ubd_pkg::LINE_IDLE;
              tx_done_set = 1'b1;
            end else begin
              next_s.tx_bit = s.tx_bit + 3'h1;
              next_s.tx_shift = {1'b0, s.tx_shift[7:1]};
              next_s.tx_pin = s.tx_shift[1];
            end
          end
        end
      end
      default: begin
        if (tx_tick16) begin
          next_s.tx_tick = s.tx_tick + 4'h1;
          if (bit_end(s.tx_tick)) begin
            next_s.tx_st = ubd_pkg::UBD_IDLE;
          end
        end
      end
    endcase

    // receive pin synchroniser; only the second and third stages are looked at
    next_s.rx_meta = rx_pin;
    next_s.rx_s = s.rx_meta;
    next_s.rx_prev = s.rx_s;

    // receiver; a frame already started runs on if enable drops
    case (s.rx_st)
      ubd_pkg::UBD_IDLE: begin
        if (receive_enable && s.rx_prev && !s.rx_s) begin
          next_s.rx_st = ubd_pkg::UBD_START;
          next_s.rx_tick = 4'h0;
        end
      end
      ubd_pkg::UBD_START: begin
        if (rx_tick16) begin
          next_s.rx_tick = s.rx_tick + 4'h1;
          if (s.rx_tick == ubd_pkg::TICK_MID) begin
            // a glitch that is high again at mid-bit is no start bit
            next_s.rx_st = s.rx_s ? ubd_pkg::UBD_IDLE : ubd_pkg::UBD_DATA;
            next_s.rx_tick = 4'h0;
            next_s.rx_bit = 3'h0;
          end
        end
      end
      ubd_pkg::UBD_DATA: begin
        if (rx_tick16) begin
          next_s.rx_tick = s.rx_tick + 4'h1;
          if (bit_end(s.rx_tick)) begin
            next_s.rx_shift = {s.rx_s, s.rx_shift[7:1]};
            next_s.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == ubd_pkg::BIT_LAST) begin
              next_s.rx_st = ubd_pkg::UBD_STOP;
            end
          end
        end
      end
      default: begin
        if (rx_tick16) begin
          next_s.rx_tick = s.rx_tick + 4'h1;
          if (bit_end(s.rx_tick)) begin
            next_s.rx_st = ubd_pkg::UBD_IDLE;
            rx_stop_done = 1'b1;
            rx_load = !s.rx_done && (!multiprocessor_check_bit || s.rx_s);
          end
        end
      end
    endcase

    // load path; a refused frame leaves buffer and flags alone
    if (rx_load) begin
      next_s.serial_buffer = s.rx_shift;
      next_s.ninth_bit = s.rx_s;
    end

    // flags: clear first so a same-cycle set wins
    if (clr_transmit_done) begin
      next_s.tx_done = 1'b0;
    end
    if (clr_receive_done) begin
      next_s.rx_done = 1'b0;
    end
    if (tx_done_set) begin
      next_s.tx_done = 1'b1;
    end
    if (rx_load) begin
      next_s.rx_done = 1'b1;
    end
    next_s.irq = interrupt_enable && (next_s.tx_done || next_s.rx_done);
    next_s.busy = (next_s.tx_st != ubd_pkg::UBD_IDLE);
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '0;
      s.tx_pin <= ubd_pkg::LINE_IDLE;
      s.rx_meta <= ubd_pkg::LINE_IDLE;
      s.rx_s <= ubd_pkg::LINE_IDLE;
      s.rx_prev <= ubd_pkg::LINE_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign tx_pin = s.tx_pin;
  assign serial_buffer = s.serial_buffer;
  assign received_ninth_bit_flag = s.ninth_bit;
  assign transmit_done_flag = s.tx_done;
  assign receive_done_flag = s.rx_done;
  assign serial_irq = s.irq;
  assign tx_busy = s.busy;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence tx_begin;
    s.tx_st == ubd_pkg::UBD_IDLE && wr_serial_buffer;
  endsequence

  sequence tx_low_start;
    s.tx_st == ubd_pkg::UBD_START && !tx_pin;
  endsequence

  a_tx_start_write: assert property (tx_begin |=> tx_low_start)
    else $error("write did not start a frame");
  a_tx_idle_high: assert property (s.tx_st == ubd_pkg::UBD_IDLE |-> tx_pin)
    else $error("idle line not high");
  a_tx_data_bit: assert property ((s.tx_st == ubd_pkg::UBD_DATA) |-> tx_pin == s.tx_shift[0])
    else $error("data bit out of order");
  a_ti_stop_begin: assert property ($rose(s.tx_st == ubd_pkg::UBD_STOP) |-> transmit_done_flag && tx_pin)
    else $error("done flag not set at stop");
  a_rx_enable_gate: assert property ((s.rx_st == ubd_pkg::UBD_IDLE && !receive_enable) |=>
    s.rx_st == ubd_pkg::UBD_IDLE) else $error("frame taken while disabled");
  a_rx_load_data: assert property (rx_load |=> receive_done_flag &&
    serial_buffer == $past(s.rx_shift)) else $error("byte not loaded");
  a_rx_ninth_bit: assert property (rx_load |=> received_ninth_bit_flag == $past(s.rx_s))
    else $error("stop bit not stored");
  a_rx_refused: assert property ((rx_stop_done && (s.rx_done || (multiprocessor_check_bit && !s.rx_s)))
    |=> $stable(serial_buffer) && $stable(received_ninth_bit_flag)) else $error("refused frame loaded");
  a_irq_follows: assert property (($rose(transmit_done_flag) || $rose(receive_done_flag)) &&
    $past(interrupt_enable) |-> serial_irq) else $error("no interrupt request");

endmodule

// ==== testbench/ubd_peer.sv ====
// remote asynchronous serial device on the far side of the mode 1 port
// assumes the bench calls its tasks; bit time is counted in core clock cycles
`timescale 1ns/1ps
module ubd_peer (
  input wire logic clock,
  input wire logic tx_line,
  output logic rx_line
);
  // -------------------------------------------------------------
  // line driver and line watcher
  // -------------------------------------------------------------
  initial begin
    rx_line = 1'b1;  // idle high, as the pull-up holds it between frames
  end

  // start low, eight data lsb first, stop; the line idles high afterwards
  task automatic send_frame(input logic [7:0] data, input logic stop, input int bit_cyc);
    logic [9:0] frame;
    frame = {stop, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      rx_line <= frame[i];
      repeat (bit_cyc - 1) @(posedge clock);
    end
    @(posedge clock);
    rx_line <= 1'b1;
  endtask

  // samples on the falling clock edge so registered changes have landed;
  // d0 must be 1 and d1 0, so the high time of d0 gives one whole bit time
  task automatic grab_frame(output logic [7:0] data, output logic stop, output int bit_cyc);
    int n;
    n = 0;
    bit_cyc = 0;
    data = 8'h01;
    while (tx_line !== 1'b0 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    while (tx_line === 1'b0 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    while (tx_line === 1'b1 && bit_cyc < 20000) begin
      @(negedge clock);
      bit_cyc++;
    end
    repeat (bit_cyc / 2) @(negedge clock);
    for (int i = 1; i < 8; i++) begin
      data[i] = tx_line;
      repeat (bit_cyc) @(negedge clock);
    end
    stop = tx_line;
  endtask
endmodule

// ==== testbench/ubd_uart_mode1_tb.sv ====
// self-checking bench for the mode 1 serial port
// assumes ubd_peer plays the remote device on the tx and rx lines
`timescale 1ns/1ps
module ubd_uart_mode1_tb;
  logic clock, rst_n, rx_pin, t1_ext_pin, baud_doubler_bit, tx_src_t2, rx_src_t2;
  logic receive_enable, multiprocessor_check_bit, interrupt_enable, wr_serial_buffer;
  logic clr_transmit_done, clr_receive_done, tx_pin, received_ninth_bit_flag;
  logic transmit_done_flag, receive_done_flag, serial_irq, tx_busy;
  logic [1:0] t1_clk_sel;
  logic [7:0] timer1_reload_byte, wr_data, serial_buffer, d, got, exp_buf;
  logic [15:0] t2_reload;
  logic stp, exp_ninth, exp_rx_done;
  int err_total, num_checks, per;
  // baud configs: timer 2, timer 1 doubled, halved, reload fd, core/12, external
  logic [5:0] c_t2 = 6'b000001;
  logic [5:0] c_dbl = 6'b111011;
  logic [7:0] c_rl [6] = '{8'hfe, 8'hfe, 8'hfe, 8'hfd, 8'hfe, 8'hfe};
  logic [1:0] c_sel [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  int c_per [6] = '{32, 32, 64, 48, 384, 64};
  // receive rows: enable, check bit, clear first, data, stop, loads
  logic [5:0] r_en = 6'b011111;
  logic [5:0] r_mp = 6'b001100;
  logic [5:0] r_clr = 6'b110101;
  logic [5:0] r_stp = 6'b101011;
  logic [5:0] r_ld = 6'b011001;
  logic [7:0] r_dat [6] = '{8'h3c, 8'hc3, 8'h5a, 8'h96, 8'h81, 8'h7e};

  ubd_uart_mode1 i_dut (.clock(clock), .rst_n(rst_n), .rx_pin(rx_pin), .t1_ext_pin(t1_ext_pin),
    .t1_clk_sel(t1_clk_sel), .timer1_reload_byte(timer1_reload_byte), .t2_reload(t2_reload),
    .baud_doubler_bit(baud_doubler_bit), .tx_src_t2(tx_src_t2), .rx_src_t2(rx_src_t2),
    .receive_enable(receive_enable), .multiprocessor_check_bit(multiprocessor_check_bit),
    .interrupt_enable(interrupt_enable), .wr_serial_buffer(wr_serial_buffer), .wr_data(wr_data),
    .clr_transmit_done(clr_transmit_done), .clr_receive_done(clr_receive_done), .tx_pin(tx_pin),
    .serial_buffer(serial_buffer), .received_ninth_bit_flag(received_ninth_bit_flag),
    .transmit_done_flag(transmit_done_flag), .receive_done_flag(receive_done_flag),
    .serial_irq(serial_irq), .tx_busy(tx_busy));
  ubd_peer i_peer (.clock(clock), .tx_line(tx_pin), .rx_line(rx_pin));

  // -------------------------------------------------------------
  // clock, external count source and helpers
  // -------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // external count pin toggles every rising clock edge: one rising edge per two cycles
  // starts itself from unknown, so no second process has to preset it
  always @(posedge clock) begin
    t1_ext_pin <= (t1_ext_pin === 1'b1) ? 1'b0 : 1'b1;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // single-cycle pulses, one edge apart so no signal is set twice at once
  task automatic wr_byte(input logic [7:0] v);
    @(posedge clock);
    wr_serial_buffer <= 1'b1;
    wr_data <= v;
    @(posedge clock);
    wr_serial_buffer <= 1'b0;
  endtask

  task automatic clr_done();
    @(posedge clock);
    {clr_transmit_done, clr_receive_done} <= 2'h3;
    @(posedge clock);
    {clr_transmit_done, clr_receive_done} <= 2'h0;
  endtask

  // a clean run takes some 76k cycles, most of it timer 2 climbing from zero;
  // this cuts a hang at 90k cycles
  initial begin
    #900000;
    err_total++;
    give_verdict();
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    err_total = 0;
    num_checks = 0;
    {rst_n, baud_doubler_bit, tx_src_t2, rx_src_t2, multiprocessor_check_bit} = 5'h0;
    {wr_serial_buffer, clr_transmit_done, clr_receive_done} = 3'h0;
    {receive_enable, interrupt_enable} = 2'h3;
    t1_clk_sel = 2'h0;
    timer1_reload_byte = 8'hfe;
    t2_reload = 16'hfffe;
    wr_data = 8'h00;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk({tx_pin, tx_busy, transmit_done_flag, receive_done_flag, serial_irq}, 16'h10);
    chk(serial_buffer, 8'h00);
    // timer 2 starts at zero and only reloads after its first rollover
    repeat (65600) @(posedge clock);
    // transmit once per baud config, with a write while busy that must be dropped
    for (int k = 0; k < 6; k++) begin
      @(posedge clock);
      tx_src_t2 <= c_t2[k];
      baud_doubler_bit <= c_dbl[k];
      timer1_reload_byte <= c_rl[k];
      t1_clk_sel <= c_sel[k];
      clr_done();
      d = {k[5:0], 2'b01};
      wr_byte(d);
      repeat (3) @(negedge clock);
      chk({tx_busy, transmit_done_flag}, 16'h2);
      wr_byte(~d);
      i_peer.grab_frame(got, stp, per);
      chk(got, d);
      chk(stp, 1'b1);
      chk(per, c_per[k]);
      chk({transmit_done_flag, serial_irq}, 16'h3);
      for (int n = 0; n < 4000 && tx_busy !== 1'b0; n++) @(negedge clock);
      repeat (40) @(negedge clock);
      chk({tx_pin, tx_busy}, 16'h2);
    end
    // receive at 32 cycles per bit from timer 2; load rules by table
    clr_done();
    rx_src_t2 <= 1'b1;
    exp_buf = 8'h00;
    exp_ninth = 1'b0;
    exp_rx_done = 1'b0;
    for (int r = 0; r < 6; r++) begin
      if (r_clr[r]) begin
        clr_done();
        exp_rx_done = 1'b0;
      end
      @(posedge clock);
      receive_enable <= r_en[r];
      multiprocessor_check_bit <= r_mp[r];
      i_peer.send_frame(r_dat[r], r_stp[r], 32);
      if (r_ld[r]) begin
        exp_buf = r_dat[r];
        exp_ninth = r_stp[r];
        exp_rx_done = 1'b1;
      end
      repeat (40) @(negedge clock);
      chk(serial_buffer, exp_buf);
      chk(received_ninth_bit_flag, exp_ninth);
      chk(receive_done_flag, exp_rx_done);
      chk(serial_irq, exp_rx_done);
    end
    @(posedge clock);
    interrupt_enable <= 1'b0;
    receive_enable <= 1'b1;
    clr_done();
    i_peer.send_frame(8'ha7, 1'b1, 32);
    repeat (40) @(negedge clock);
    chk({receive_done_flag, serial_irq, serial_buffer}, 16'h2a7);
    give_verdict();
  end
endmodule
